// ---- alu_inst_timing.sv ----
/*
 * Decode and timing control for the arithmetic and logic instruction group.
 * Takes one opcode per handshake, reports its encoded length, its cycle
 * count and its group, and holds busy for exactly that many cycles.
 * Assumes the fetch unit presents a whole opcode synchronous to I_CLK_SYS.
 */
// Functional notes
// - Plain sum: one cycle; register, indirect one byte; direct, immediate two.
// - Sum with carry: one cycle; register, indirect one byte; else two.
// - Difference with borrow: one cycle; register, indirect one byte; else two.
// - AND to accumulator: reg/ind 1B1C, direct 2B2C, immediate 2B1C.
// - AND to direct byte: two cycles; accumulator source 2B, immediate 3B.
// - OR to accumulator: reg/ind 1B1C, direct 2B2C, immediate 2B1C.
// - OR to direct byte: two cycles; accumulator source 2B, immediate 3B.
// - XOR to accumulator: reg/ind 1B1C, direct 2B2C, immediate 2B1C.
// - XOR to direct byte: two cycles; accumulator source 2B, immediate 3B.
// - Clear, invert, rotate left, through carry, right: one cycle each.
`timescale 1ns/10ps
`default_nettype none
module alu_inst_timing
   import alu_timing_pkg::*;
(
   input  wire logic              I_CLK_SYS,
   input  wire logic              I_ARST_N,
   input  wire logic              I_OP_VALID,
   input  wire logic [7:0]        I_OPCODE,
   output logic                   O_OP_READY,
   output logic                   O_BUSY,
   output logic                   O_DONE,
   output logic [LEN_W-1:0]       O_INST_LEN,
   output logic [CYC_W-1:0]       O_INST_CYCLES,
   output group_type              O_GROUP,
   output logic                   O_SUPPORTED
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   form_type              form;
   logic [3:0]            hi;
   logic                  accept;
   logic                  last_cycle;
   logic                  cnt_zero;
   logic                  is_single;
   logic                  is_arith;
   logic                  is_step;
   logic                  is_logic;
   logic                  supported;
   logic                  acc_dest_dir;
   logic                  short_form;
   group_type             grp_single;
   group_type             grp_row;
   group_type             grp_dec;
   logic [LEN_W-1:0]      len_dec;
   logic [CYC_W-1:0]      cyc_dec;
   logic [CYC_W-1:0]      cyc_single;
   logic [CYC_W-1:0]      cyc_logic;
   logic [LEN_W-1:0]      len_row;
   logic [CYC_W-1:0]      cyc_row;
   state_type             state_r;
   state_type             state_nxt;
   logic [LEN_W-1:0]      len_r;
   logic [CYC_W-1:0]      cyc_r;
   group_type             grp_r;
   logic                  sup_r;

   // ****************************************************************
   // Operand form and group decode
   // ****************************************************************
   opcode_form_decode u_form (
      .i_low_nibble (I_OPCODE[3:0]),
      .o_form       (form)
   );

   assign hi = I_OPCODE[7:4];

   // Whole-opcode instructions take priority over row decode
   assign grp_single = (I_OPCODE == OP_ZERO_ACC   ||
                        I_OPCODE == OP_INVERT_ACC ||
                        I_OPCODE == OP_ROT_LEFT   ||
                        I_OPCODE == OP_ROT_LEFT_C ||
                        I_OPCODE == OP_ROT_RIGHT)  ? GRP_ACC_UNARY :
                       (I_OPCODE == OP_PTR_UP)     ? GRP_PTR_STEP  :
                       (I_OPCODE == OP_PRODUCT)    ? GRP_PRODUCT   :
                       (I_OPCODE == OP_QUOTIENT)   ? GRP_QUOTIENT  :
                       (I_OPCODE == OP_DEC_ADJ)    ? GRP_DEC_ADJ   : GRP_NONE;
   assign is_single  = (grp_single != GRP_NONE);

   // Row groups: form 4..F for arithmetic and steps, 2..F for logic
   assign short_form = (form == FORM_IMM) || (form == FORM_DIR) ||
                       (form == FORM_IND) || (form == FORM_REG);
   assign is_arith   = short_form && (hi == HI_SUM || hi == HI_SUMC || hi == HI_DIFF);
   assign is_step    = short_form && (hi == HI_STEP_UP || hi == HI_STEP_DOWN);
   assign is_logic   = (form != FORM_NONE) && (hi == HI_OR || hi == HI_AND || hi == HI_XOR);
   assign supported  = is_single || is_arith || is_step || is_logic;

   assign grp_row = (hi == HI_SUM)       ? GRP_SUM       :
                    (hi == HI_SUMC)      ? GRP_SUMC      :
                    (hi == HI_DIFF)      ? GRP_DIFF      :
                    (hi == HI_STEP_UP)   ? GRP_STEP_UP   :
                    (hi == HI_STEP_DOWN) ? GRP_STEP_DOWN :
                    (hi == HI_AND)       ? GRP_AND       :
                    (hi == HI_OR)        ? GRP_OR        :
                    (hi == HI_XOR)       ? GRP_XOR       : GRP_NONE;

   // ****************************************************************
   // Length and cycle selection
   // ****************************************************************
   // Single opcodes are all one byte long
   assign cyc_single = (grp_single == GRP_PTR_STEP) ? CYC_PTR_UP   :
                       (grp_single == GRP_PRODUCT)  ? CYC_PRODUCT  :
                       (grp_single == GRP_QUOTIENT) ? CYC_QUOTIENT : CYC_ONE;

   // Register and indirect forms are one byte; the step group's
   // nibble-4 slot names the accumulator rather than immediate data
   assign len_row = (form == FORM_DIR_IMM)                     ? LEN_THREE :
                    (form == FORM_REG || form == FORM_IND)     ? LEN_ONE   :
                    (is_step && form == FORM_IMM)              ? LEN_ONE   :
                                                                 LEN_TWO;

   // Logic group: direct operand or direct destination cost two cycles
   assign acc_dest_dir = (form == FORM_DIR) || (form == FORM_DIR_ACC) ||
                         (form == FORM_DIR_IMM);
   assign cyc_logic    = acc_dest_dir ? CYC_TWO : CYC_ONE;

   // Arithmetic is always single cycle; steps pay two on a direct byte
   assign cyc_row = is_logic                     ? cyc_logic :
                    (is_step && form == FORM_DIR) ? CYC_TWO   :
                                                    CYC_ONE;

   // Unsupported opcodes occupy one slot of one byte and are flagged
   assign grp_dec = is_single ? grp_single : (supported ? grp_row : GRP_NONE);
   assign len_dec = is_single ? LEN_ONE    : (supported ? len_row : LEN_ONE);
   assign cyc_dec = is_single ? cyc_single : (supported ? cyc_row : CYC_ONE);

   // ****************************************************************
   // Execution timing
   // ****************************************************************
   cycle_countdown #(
      .W (CYC_W)
   ) u_count (
      .i_clk    (I_CLK_SYS),
      .i_arst_n (I_ARST_N),
      .i_load   (accept),
      .i_value  (cyc_dec - CYC_W'(1)),
      .o_zero   (cnt_zero)
   );

   // Handshake: a new opcode may follow in the last busy cycle
   assign last_cycle = (state_r == ST_EXEC) && cnt_zero;
   assign O_OP_READY = (state_r == ST_IDLE) || last_cycle;
   assign accept     = I_OP_VALID && O_OP_READY;
   assign O_DONE     = last_cycle;
   assign O_BUSY     = (state_r == ST_EXEC);

   // Next state
   always_comb begin
      unique case (state_r)
         ST_IDLE: begin
            state_nxt = accept ? ST_EXEC : ST_IDLE;
         end
         ST_EXEC: begin
            state_nxt = (last_cycle && !accept) ? ST_IDLE : ST_EXEC;
         end
      endcase
   end

   // State register
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Decoded results captured at acceptance
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         len_r <= '0;
         cyc_r <= '0;
         grp_r <= GRP_NONE;
         sup_r <= 1'b0;
      end else if (accept) begin
         len_r <= len_dec;
         cyc_r <= cyc_dec;
         grp_r <= grp_dec;
         sup_r <= supported;
      end
   end

   assign O_INST_LEN    = len_r;
   assign O_INST_CYCLES = cyc_r;
   assign O_GROUP       = grp_r;
   assign O_SUPPORTED   = sup_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   logic       acc_q;
   logic [3:0] run_len;

   // Cycles spent in the current instruction, for the length checks
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         acc_q   <= 1'b0;
         run_len <= '0;
      end else begin
         acc_q   <= accept;
         run_len <= accept ? 4'h1 : (O_BUSY ? run_len + 4'h1 : 4'h0);
      end
   end

   sequence s_take(logic [7:0] op);
      accept && (I_OPCODE == op);
   endsequence

   sequence s_run_ten;
      !O_DONE [*8] ##1 !O_DONE ##1 O_DONE;
   endsequence

   AST_SUM_REG: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && hi == HI_SUM && form == FORM_REG |=> O_INST_LEN == LEN_ONE && O_DONE)
      else $error("plain sum on register not one byte one cycle");

   AST_SUMC_IMM: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && hi == HI_SUMC && form == FORM_IMM |=> O_INST_LEN == LEN_TWO && O_DONE)
      else $error("sum with carry immediate not two bytes one cycle");

   AST_DIFF_DIR: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && hi == HI_DIFF && form == FORM_DIR |=> O_INST_LEN == LEN_TWO && O_DONE)
      else $error("difference direct not two bytes one cycle");

   AST_LOGIC_ACC_DIR: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_ARST_N)
      accept && is_logic && form == FORM_DIR |=> !O_DONE ##1 O_DONE && run_len == 4'h2)
      else $error("logic direct to accumulator not two cycles");

   AST_LOGIC_ACC_IMM: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_ARST_N)
      accept && is_logic && form == FORM_IMM |=> O_DONE && O_INST_LEN == LEN_TWO)
      else $error("logic immediate to accumulator not two bytes one cycle");

   AST_LOGIC_DIR_IMM: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_ARST_N)
      accept && is_logic && form == FORM_DIR_IMM
      |=> O_INST_LEN == LEN_THREE && O_INST_CYCLES == CYC_TWO ##1 O_DONE)
      else $error("logic immediate to direct byte not three bytes two cycles");

   AST_UNARY: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      s_take(OP_ROT_LEFT_C) or s_take(OP_ZERO_ACC) |=> O_DONE && O_GROUP == GRP_ACC_UNARY)
      else $error("accumulator unary op not one cycle");

   AST_PTR_STEP: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      s_take(OP_PTR_UP) |=> !O_DONE [*2] ##1 O_DONE && O_INST_LEN == LEN_ONE)
      else $error("pointer step not one byte three cycles");

   AST_STEP_DIR: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && is_step && form == FORM_DIR |=> O_INST_LEN == LEN_TWO && !O_DONE ##1 O_DONE)
      else $error("step on direct byte not two bytes two cycles");

   AST_QUOTIENT: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      s_take(OP_QUOTIENT) |=> s_run_ten)
      else $error("quotient not ten cycles");

   AST_PRODUCT: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      s_take(OP_PRODUCT) |=> O_BUSY throughout (!O_DONE [*2] ##1 O_DONE))
      else $error("product not three cycles");

   AST_BUSY_BOUND: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      O_BUSY |-> run_len <= 4'hA)
      else $error("instruction ran past ten cycles");

   // Two-cycle ending: one waiting cycle, then the last cycle
   sequence s_done_second;
      !O_DONE ##1 O_DONE;
   endsequence

   AST_TAKE_BUSY: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      acc_q |-> O_BUSY)
      else $error("no busy cycle after an accepted opcode");

   AST_SUM_IND: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && hi == HI_SUM && form == FORM_IND |=> O_INST_LEN == LEN_ONE && O_DONE)
      else $error("plain sum indirect not one byte one cycle");

   AST_SUMC_REG: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && hi == HI_SUMC && form == FORM_REG |=> O_INST_LEN == LEN_ONE && O_DONE)
      else $error("sum with carry register not one byte one cycle");

   AST_DIFF_IMM: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && hi == HI_DIFF && form == FORM_IMM |=> O_INST_LEN == LEN_TWO && O_DONE)
      else $error("difference immediate not two bytes one cycle");

   AST_LOGIC_ACC_REG: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_ARST_N)
      accept && is_logic && (form == FORM_REG || form == FORM_IND)
      |=> O_INST_LEN == LEN_ONE && O_DONE)
      else $error("logic register or indirect not one byte one cycle");

   AST_LOGIC_DIR_ACC: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_ARST_N)
      accept && is_logic && form == FORM_DIR_ACC |=> O_INST_LEN == LEN_TWO ##0 s_done_second)
      else $error("logic accumulator to direct byte not two bytes two cycles");

   AST_STEP_ACC: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && is_step && form == FORM_IMM |=> O_INST_LEN == LEN_ONE && O_DONE)
      else $error("step on accumulator not one byte one cycle");

   AST_DEC_ADJ: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      s_take(OP_DEC_ADJ) |=> O_DONE && O_INST_LEN == LEN_ONE && O_GROUP == GRP_DEC_ADJ)
      else $error("decimal adjust not one byte one cycle");

   AST_UNSUPPORTED: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      accept && !supported |=> O_DONE && !O_SUPPORTED && O_GROUP == GRP_NONE)
      else $error("foreign opcode not flagged as one cycle unsupported");

endmodule // alu_inst_timing
`default_nettype wire

// ---- alu_timing_pkg.sv ----
/*
 * Package of the arithmetic and logic instruction timing block:
 * opcode values, operand forms, group codes, byte lengths and cycle counts.
 * Assumes an 8-bit opcode set in the classic accumulator-machine layout.
 */
package alu_timing_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int LEN_W = 2;
   localparam int CYC_W = 4;

   // ****************************************************************
   // Opcode high nibbles of the row-encoded groups
   // ****************************************************************
   localparam logic [3:0] HI_STEP_UP   = 4'h0;
   localparam logic [3:0] HI_STEP_DOWN = 4'h1;
   localparam logic [3:0] HI_SUM       = 4'h2;
   localparam logic [3:0] HI_SUMC      = 4'h3;
   localparam logic [3:0] HI_OR        = 4'h4;
   localparam logic [3:0] HI_AND       = 4'h5;
   localparam logic [3:0] HI_XOR       = 4'h6;
   localparam logic [3:0] HI_DIFF      = 4'h9;

   // ****************************************************************
   // Single opcodes
   // ****************************************************************
   localparam logic [7:0] OP_ZERO_ACC   = 8'hE4;
   localparam logic [7:0] OP_INVERT_ACC = 8'hF4;
   localparam logic [7:0] OP_ROT_LEFT   = 8'h23;
   localparam logic [7:0] OP_ROT_LEFT_C = 8'h33;
   localparam logic [7:0] OP_ROT_RIGHT  = 8'h03;
   localparam logic [7:0] OP_PTR_UP     = 8'hA3;
   localparam logic [7:0] OP_PRODUCT    = 8'hA4;
   localparam logic [7:0] OP_QUOTIENT   = 8'h84;
   localparam logic [7:0] OP_DEC_ADJ    = 8'hD4;

   // ****************************************************************
   // Low nibble form codes
   // ****************************************************************
   localparam logic [3:0] LO_DIR_ACC = 4'h2;
   localparam logic [3:0] LO_DIR_IMM = 4'h3;
   localparam logic [3:0] LO_IMM     = 4'h4;
   localparam logic [3:0] LO_DIR     = 4'h5;

   // ****************************************************************
   // Byte lengths
   // ****************************************************************
   localparam logic [LEN_W-1:0] LEN_ONE   = 2'd1;
   localparam logic [LEN_W-1:0] LEN_TWO   = 2'd2;
   localparam logic [LEN_W-1:0] LEN_THREE = 2'd3;

   // ****************************************************************
   // Machine cycle counts
   // ****************************************************************
   localparam logic [CYC_W-1:0] CYC_ONE      = 4'h1;
   localparam logic [CYC_W-1:0] CYC_TWO      = 4'h2;
   localparam logic [CYC_W-1:0] CYC_PTR_UP   = 4'h3;
   localparam logic [CYC_W-1:0] CYC_PRODUCT  = 4'h3;
   localparam logic [CYC_W-1:0] CYC_QUOTIENT = 4'hA;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      FORM_NONE, FORM_DIR_ACC, FORM_DIR_IMM, FORM_IMM, FORM_DIR, FORM_IND, FORM_REG
   } form_type;

   typedef enum logic [3:0] {
      GRP_NONE, GRP_SUM, GRP_SUMC, GRP_DIFF, GRP_STEP_UP, GRP_STEP_DOWN,
      GRP_AND, GRP_OR, GRP_XOR, GRP_ACC_UNARY, GRP_PTR_STEP,
      GRP_PRODUCT, GRP_QUOTIENT, GRP_DEC_ADJ
   } group_type;

   typedef enum logic {ST_IDLE, ST_EXEC} state_type;

endpackage : alu_timing_pkg

// ---- opcode_form_decode.sv ----
/*
 * Splits the low nibble of an opcode into its operand form.
 * Assumes the row layout: 2/3 direct destination, 4 immediate, 5 direct,
 * 6-7 indirect pointer register, 8-F bank register.
 */
`timescale 1ns/10ps
`default_nettype none
module opcode_form_decode
   import alu_timing_pkg::*;
(
   input  wire logic [3:0] i_low_nibble,
   output form_type        o_form
);

   // Form selection from the nibble value
   assign o_form = i_low_nibble[3]          ? FORM_REG     :
                   (i_low_nibble[3:1] == 3'b011) ? FORM_IND :
                   (i_low_nibble == LO_DIR)     ? FORM_DIR     :
                   (i_low_nibble == LO_IMM)     ? FORM_IMM     :
                   (i_low_nibble == LO_DIR_IMM) ? FORM_DIR_IMM :
                   (i_low_nibble == LO_DIR_ACC) ? FORM_DIR_ACC : FORM_NONE;

endmodule // opcode_form_decode
`default_nettype wire

// ---- cycle_countdown.sv ----
/*
 * Loadable down counter that marks the last cycle of an instruction.
 * Assumes load and the count value arrive on the same clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module cycle_countdown #(
   parameter int W = 4
) (
   input  wire logic         i_clk,
   input  wire logic         i_arst_n,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_value,
   output logic              o_zero
);

   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   // Load wins, otherwise count down to zero and hold
   assign count_nxt = i_load ? i_value :
                      (count_r != '0) ? count_r - W'(1) : count_r;
   assign o_zero    = (count_r == '0);

   // Counter register
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

endmodule // cycle_countdown
`default_nettype wire

// ---- fetch_model.sv ----
/*
 * Behavioural program fetch unit that offers opcodes to the timing block.
 * Assumes the timing block accepts on a rising edge with valid and ready.
 */
`timescale 1ns/10ps
`default_nettype none
module fetch_model
   import alu_timing_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_ready,
   output logic            o_valid,
   output logic [7:0]      o_opcode,
   output logic            o_idle
);
   // ****************************************************************
   // Request queue filled by the bench
   // ****************************************************************
   logic [7:0] op_q[$];
   int         gap_q[$];
   int         gap;

   task automatic push_op(input logic [7:0] op, input int g);
      op_q.push_back(op);
      gap_q.push_back(g);
   endtask

   // Offer one opcode after the gap, hold it until taken, chain a next one that has no gap, then release
   initial begin
      o_valid  = 1'b0;
      o_opcode = 8'h00;
      o_idle   = 1'b1;
      wait (i_arst_n === 1'b1);
      forever begin
         @(posedge i_clk);
         #1;
         if (op_q.size() != 0) begin
            o_idle = 1'b0;
            gap    = gap_q.pop_front();
            repeat (gap) @(posedge i_clk);
            if (gap != 0) #1;
            o_valid  = 1'b1;
            o_opcode = op_q.pop_front();
            // Ready is settled at the falling edge before the taking edge
            do @(negedge i_clk); while (i_ready !== 1'b1);
            @(posedge i_clk);
            #1;
            // Released opcode lines show a changed value, not the last one
            o_valid  = (op_q.size() != 0) && (gap_q[0] == 0);
            o_opcode = o_valid ? op_q[0] : ~o_opcode;
            if (o_valid) begin
               void'(gap_q.pop_front());
               void'(op_q.pop_front());
               do @(negedge i_clk); while (i_ready !== 1'b1);
               @(posedge i_clk);
               #1;
               o_valid  = 1'b0;
               o_opcode = ~o_opcode;
            end
            o_idle = (op_q.size() == 0);
         end
      end
   end
endmodule // fetch_model
`default_nettype wire

// ---- tb.sv ----
/*
 * Self-checking bench of the instruction timing block.
 * Assumes the fetch model serialises opcodes in the order they are pushed.
 */
`timescale 1ns/10ps
`default_nettype none
module tb
   import alu_timing_pkg::*;
;
   typedef struct packed {
      logic [LEN_W-1:0] len;
      logic [CYC_W-1:0] cyc;
      group_type        grp;
      logic             sup;
   } exp_type;

   logic             I_CLK_SYS;
   logic             I_ARST_N;
   logic             I_OP_VALID;
   logic [7:0]       I_OPCODE;
   logic             O_OP_READY;
   logic             O_BUSY;
   logic             O_DONE;
   logic [LEN_W-1:0] O_INST_LEN;
   logic [CYC_W-1:0] O_INST_CYCLES;
   group_type        O_GROUP;
   logic             O_SUPPORTED;
   logic             idle;
   int               num_errors = 0;
   int               n_checks = 0;
   int               cnt = 0;
   exp_type          exp_q[$];
   exp_type          e;
   logic [7:0]       op;

   alu_inst_timing alu_inst_timing_i (.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N),
      .I_OP_VALID(I_OP_VALID), .I_OPCODE(I_OPCODE), .O_OP_READY(O_OP_READY),
      .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_INST_LEN(O_INST_LEN),
      .O_INST_CYCLES(O_INST_CYCLES), .O_GROUP(O_GROUP), .O_SUPPORTED(O_SUPPORTED));

   fetch_model fetch_model_i (.i_clk(I_CLK_SYS), .i_arst_n(I_ARST_N), .i_ready(O_OP_READY),
      .o_valid(I_OP_VALID), .o_opcode(I_OPCODE), .o_idle(idle));

   // ****************************************************************
   // Expected length, cycles and group of an opcode
   // ****************************************************************
   function automatic exp_type exp_of(input logic [7:0] op);
      exp_type    x;
      logic [3:0] h;
      logic [3:0] l;
      logic       ind_reg;
      h       = op[7:4];
      l       = op[3:0];
      x       = '{LEN_ONE, CYC_ONE, GRP_NONE, 1'b0};
      ind_reg = (l >= 4'h6);
      if ((h inside {HI_SUM, HI_SUMC, HI_DIFF}) && l >= 4'h4) begin
         x.grp = (h == HI_SUM) ? GRP_SUM : (h == HI_SUMC) ? GRP_SUMC : GRP_DIFF;
         x.sup = 1'b1;
         x.len = ind_reg ? LEN_ONE : LEN_TWO;
      end else if ((h inside {HI_STEP_UP, HI_STEP_DOWN}) && l >= 4'h4) begin
         x.grp = (h == HI_STEP_UP) ? GRP_STEP_UP : GRP_STEP_DOWN;
         x.sup = 1'b1;
         if (l == LO_DIR) x = '{LEN_TWO, CYC_TWO, x.grp, 1'b1};
      end else if ((h inside {HI_OR, HI_AND, HI_XOR}) && l >= 4'h2) begin
         x.grp = (h == HI_OR) ? GRP_OR : (h == HI_AND) ? GRP_AND : GRP_XOR;
         x.sup = 1'b1;
         if (!ind_reg) x.len = (l == LO_DIR_IMM) ? LEN_THREE : LEN_TWO;
         if (l inside {LO_DIR_ACC, LO_DIR_IMM, LO_DIR}) x.cyc = CYC_TWO;
      end else begin
         case (op)
            OP_ZERO_ACC, OP_INVERT_ACC, OP_ROT_LEFT, OP_ROT_LEFT_C, OP_ROT_RIGHT:
               x = '{LEN_ONE, CYC_ONE, GRP_ACC_UNARY, 1'b1};
            OP_PTR_UP:   x = '{LEN_ONE, CYC_PTR_UP, GRP_PTR_STEP, 1'b1};
            OP_PRODUCT:  x = '{LEN_ONE, CYC_PRODUCT, GRP_PRODUCT, 1'b1};
            OP_QUOTIENT: x = '{LEN_ONE, CYC_QUOTIENT, GRP_QUOTIENT, 1'b1};
            OP_DEC_ADJ:  x = '{LEN_ONE, CYC_ONE, GRP_DEC_ADJ, 1'b1};
            default:     x = '{LEN_ONE, CYC_ONE, GRP_NONE, 1'b0};
         endcase
      end
      return x;
   endfunction

   // Compare one value and count it
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic send(input logic [7:0] op, input int gap);
      exp_q.push_back(exp_of(op));
      fetch_model_i.push_op(op, gap);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Clock and watchdog
   // ****************************************************************
   initial begin
      I_CLK_SYS = 1'b0;
      forever #25 I_CLK_SYS = ~I_CLK_SYS;
   end

   initial begin
      #1500000;
      num_errors++;
      tally_and_finish();
   end

   // Monitor: counts cycles from each taking edge and checks results at done
   always @(negedge I_CLK_SYS) begin
      if (I_ARST_N === 1'b1) begin
         cnt++;
         if (O_BUSY === 1'b1 && O_DONE !== 1'b1) check("ready_busy", 8'h00, O_OP_READY);
         if (O_DONE === 1'b1) begin
            if (exp_q.size() == 0) begin
               check("queue", 8'h01, 8'h00);
            end else begin
               e = exp_q.pop_front();
               check("len", e.len, O_INST_LEN);
               check("cycles", e.cyc, O_INST_CYCLES);
               check("done_at", e.cyc, cnt[7:0]);
               check("group", e.grp, O_GROUP);
               check("supported", e.sup, O_SUPPORTED);
               check("busy", 8'h01, O_BUSY);
            end
         end
         if (I_OP_VALID === 1'b1 && O_OP_READY === 1'b1) cnt = 0;
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      int k;
      I_ARST_N = 1'b0;
      void'($urandom(52));
      repeat (2) @(posedge I_CLK_SYS);
      #1 I_ARST_N = 1'b1;
      @(negedge I_CLK_SYS);
      check("rst_ready", 8'h01, O_OP_READY);
      check("rst_busy", 8'h00, {O_BUSY, O_DONE, O_SUPPORTED});
      check("rst_len", 8'h00, {O_INST_LEN, O_INST_CYCLES});
      check("rst_group", GRP_NONE, O_GROUP);
      // Every row form back to back, then the single opcodes with gaps
      for (int h = 0; h < 16; h++) begin
         if (h inside {0, 1, 2, 3, 4, 5, 6, 9}) begin
            for (int l = 2; l < 16; l++) send({h[3:0], l[3:0]}, 0);
         end
      end
      send(OP_QUOTIENT, 1);
      send(OP_PRODUCT, 0);
      send(OP_PTR_UP, 2);
      send(OP_DEC_ADJ, 0);
      send(OP_ZERO_ACC, 1);
      send(OP_INVERT_ACC, 0);
      send(8'h00, 0);
      send(8'h74, 1);
      // Random opcodes with random gaps
      repeat (80) begin
         op = 8'($urandom_range(0, 255));
         if (op != 8'h13 && op != 8'hC4) send(op, $urandom_range(0, 2));
      end
      for (k = 0; k < 20000 && exp_q.size() != 0; k++) @(posedge I_CLK_SYS);
      check("pending", 8'h00, 8'(exp_q.size()));
      check("fetch_idle", 8'h01, idle);
      repeat (3) @(posedge I_CLK_SYS);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
